// *** rtl/dps_top.sv ***
// Over-current retry, PWM gating, start-up and missing-load status bits
`default_nettype none
module dps_top #(
  parameter int OL_FILTER_CYCLES = dps_pkg::OL_FILTER_CYCLES,
  parameter int STARTUP_CYCLES   = dps_pkg::STARTUP_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       ctrl_wr,
  input  wire logic [15:0]                ctrl_wdata,
  input  wire logic                       oc_clear,
  input  wire logic [dps_pkg::NUM_OUT-1:0] out_on,
  input  wire logic [dps_pkg::NUM_OUT-1:0] oc_detect,
  input  wire logic [dps_pkg::NUM_OUT-1:0] below_thresh,
  input  wire logic                       active_mode,
  input  wire logic                       pwm_in,
  output logic      [dps_pkg::NUM_OUT-1:0] drive_on,
  output logic      [dps_pkg::NUM_OUT-1:0] oc_flag,
  output logic                            not_ready,
  output logic      [15:0]                status_word
);
  import dps_pkg::*;

  dps_ctrl_type            ctrl;
  logic [15:0]             div_cnt;
  logic                    tick;
  logic [NUM_OUT-1:0]      tripped;
  logic [NUM_OUT-1:0]      one_shot;
  logic [NUM_OUT-1:0]      retry_en_vec;
  logic [NUM_OUT-1:0]      next_drive;
  logic [7:0]              retry_cnt [NUM_OUT];
  logic [7:0]              retry_limit;
  logic [31:0]             startup_cnt;
  logic                    active_prev;
  logic [NUM_OL-1:0]       ol_flag;
  logic [15:0]             next_status;
  logic [31:0]             nr_len;

  // Output number (0 = first half bridge) that owns each stage bit
  function automatic logic [2:0] out_num(input int i);
    case (i)
      0, 1:    out_num = 3'h0;
      2, 3:    out_num = 3'h1;
      4, 5:    out_num = 3'h2;
      6:       out_num = 3'h3;
      default: out_num = 3'h4;
    endcase
  endfunction

  // ==========================================================================
  // Control word storage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl <= CTRL_RESET;
    else if (ctrl_wr)
    begin
      ctrl.duty_long <= ctrl_wdata[CTRL_DUTY];
      ctrl.retry_en  <= ctrl_wdata[CTRL_RETRY_MSB:CTRL_RETRY_LSB];
      ctrl.pwm_en    <= ctrl_wdata[CTRL_PWM_MSB:CTRL_PWM_LSB];
    end
  end

  // ==========================================================================
  // Retry time base; trips are sampled against its phase, which is why
  // an unlucky trip may still earn one retry
  assign tick = (div_cnt == RETRY_DIV - 16'h0001);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_cnt <= 16'h0000;
    else if (tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // Off time in retry ticks selects the duty of the pulsed current
  assign retry_limit = ctrl.duty_long ? RETRY_LONG_TICKS : RETRY_SHORT_TICKS;

  always_comb
  begin
    for (int i = 0; i < NUM_OUT; i++)
      retry_en_vec[i] = ctrl.retry_en[out_num(i)];
  end

  // ==========================================================================
  // Trip and retry per stage; a trip beats a host clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tripped  <= '0;
      one_shot <= '0;
      for (int i = 0; i < NUM_OUT; i++)
        retry_cnt[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        if (oc_detect[i] && drive_on[i])
        begin
          tripped[i]   <= 1'b1;
          retry_cnt[i] <= 8'h00;
          one_shot[i]  <= tick && !retry_en_vec[i];
        end
        else if (oc_clear)
        begin
          tripped[i]   <= 1'b0;
          one_shot[i]  <= 1'b0;
          retry_cnt[i] <= 8'h00;
        end
        else if (tripped[i] && tick && (retry_en_vec[i] || one_shot[i]))
        begin
          if (retry_cnt[i] == retry_limit - 8'h01)
          begin
            tripped[i]   <= 1'b0;
            one_shot[i]  <= 1'b0;
            retry_cnt[i] <= 8'h00;
          end
          else
            retry_cnt[i] <= retry_cnt[i] + 8'h01;
        end
      end
    end
  end

  // Sticky over-current flags, cleared only by the host reset bit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      oc_flag <= '0;
    else
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        if (oc_detect[i] && drive_on[i])
          oc_flag[i] <= 1'b1;
        else if (oc_clear)
          oc_flag[i] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Start-up settling timer, restarted on every exit from standby
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active_prev <= 1'b0;
      startup_cnt <= 32'h0000_0000;
    end
    else
    begin
      active_prev <= active_mode;
      if (active_mode && !active_prev)
        startup_cnt <= 32'(STARTUP_CYCLES);
      else if (startup_cnt != 32'h0000_0000)
        startup_cnt <= startup_cnt - 32'h0000_0001;
    end
  end

  assign not_ready = (startup_cnt != 32'h0000_0000);

  // ==========================================================================
  // Stage drive: enables, trips, start-up hold and PWM gating
  // A fresh trip or a start-up just begun cuts drive in the same edge,
  // so no stray cycle of drive leaks out before the flags take effect
  always_comb
  begin
    for (int i = 0; i < NUM_OUT; i++)
      next_drive[i] = out_on[i] && !tripped[i] && !not_ready
                      && active_mode && active_prev
                      && !(oc_detect[i] && drive_on[i]);
    if (ctrl.pwm_en[1] && !pwm_in)
      next_drive[NUM_OUT-1] = 1'b0;
    if (ctrl.pwm_en[0] && !pwm_in)
      next_drive[NUM_OUT-2] = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      drive_on <= '0;
    else
      drive_on <= next_drive;
  end

  // ==========================================================================
  // Missing-load filter on the five monitored stages
  dps_ol_filter #(
    .FILTER_CYCLES (OL_FILTER_CYCLES)
  ) u_ol (
    .clk      (clk),
    .nrst     (nrst),
    .clear    (oc_clear),
    .stage_on (drive_on[OL_BASE+NUM_OL-1:OL_BASE]),
    .below    (below_thresh[OL_BASE+NUM_OL-1:OL_BASE]),
    .flag     (ol_flag)
  );

  // Status word image; bits outside this block read zero
  always_comb
  begin
    next_status = STATUS_RESET;
    next_status[ST_NOT_READY] = not_ready;
    next_status[ST_UNUSED] = 1'b0;
    next_status[ST_OL_MSB:ST_OL_LSB] = ol_flag;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      status_word <= STATUS_RESET;
    else
      status_word <= next_status;
  end

  // ==========================================================================
  // Checks and their helper logic
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      nr_len <= 32'h0000_0000;
    else if (not_ready)
      nr_len <= nr_len + 32'h0000_0001;
    else
      nr_len <= 32'h0000_0000;
  end

  sequence s_oc_hit;
    (oc_detect & drive_on) != '0;
  endsequence

  oc_trip_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    s_oc_hit |=> ((drive_on & $past(oc_detect & drive_on)) == '0)
      && ((oc_flag & $past(oc_detect & drive_on))
          == $past(oc_detect & drive_on)))
    else $error("tripped stage still driven or flag missing");

  retry_allowed_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !$past(oc_clear) |-> (($past(tripped) & ~tripped
      & ~$past(retry_en_vec | one_shot)) == '0))
    else $error("stage released without retry permission");

  not_ready_start_a: assert property (
    @(posedge clk) disable iff (!nrst)
    active_mode && !active_prev |=> not_ready [*2])
    else $error("not-ready missing after leaving standby");

  outputs_idle_a: assert property (
    @(posedge clk) disable iff (!nrst)
    not_ready |=> drive_on == '0)
    else $error("stage driven during start-up");

  not_ready_len_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(not_ready) |-> $past(nr_len) >= 32'(STARTUP_CYCLES - 1))
    else $error("not-ready shorter than start-up time");

  unused_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    status_word[ST_UNUSED] == 1'b0)
    else $error("unused status bit not zero");

  pwm_gate_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ctrl.pwm_en[1] && !pwm_in |=> !drive_on[NUM_OUT-1])
    else $error("gated stage on while PWM input low");
endmodule
`default_nettype wire

// *** rtl/dps_pkg.sv ***
// Constants, field positions and carrier types for the protection status bits
`default_nettype none
package dps_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int OL_FILTER_US     = 1000;
  // Least time, rounded up to whole cycles
  localparam int OL_FILTER_CYCLES =
    (OL_FILTER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STARTUP_CYCLES   = 20000;
  localparam logic [15:0] RETRY_DIV         = 16'h00FA;
  localparam logic [7:0]  RETRY_SHORT_TICKS = 8'h0A;
  localparam logic [7:0]  RETRY_LONG_TICKS  = 8'h28;

  // ==========================================================================
  // Geometry
  localparam int NUM_OUT = 8;
  localparam int NUM_OL  = 5;
  localparam int OL_BASE = 3;

  // ==========================================================================
  // Control word field positions
  localparam int CTRL_DUTY      = 13;
  localparam int CTRL_RETRY_MSB = 10;
  localparam int CTRL_RETRY_LSB = 6;
  localparam int CTRL_PWM_MSB   = 5;
  localparam int CTRL_PWM_LSB   = 4;

  // ==========================================================================
  // Status word field positions
  localparam int ST_NOT_READY = 10;
  localparam int ST_UNUSED    = 9;
  localparam int ST_OL_MSB    = 8;
  localparam int ST_OL_LSB    = 4;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ==========================================================================
  // Stored control fields
  typedef struct packed {
    logic       duty_long;
    logic [4:0] retry_en;
    logic [1:0] pwm_en;
  } dps_ctrl_type;
  localparam dps_ctrl_type CTRL_RESET = 8'h00;
endpackage
`default_nettype wire

// *** rtl/dps_ol_filter.sv ***
// Missing-load detection filter for the switched-on output stages
`default_nettype none
module dps_ol_filter #(
  parameter int FILTER_CYCLES = dps_pkg::OL_FILTER_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      clear,
  input  wire logic [dps_pkg::NUM_OL-1:0] stage_on,
  input  wire logic [dps_pkg::NUM_OL-1:0] below,
  output logic      [dps_pkg::NUM_OL-1:0] flag
);
  import dps_pkg::*;

  logic [31:0] cnt [NUM_OL];

  // ==========================================================================
  // Per-channel low-current timers; any gap in the low condition restarts
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < NUM_OL; k++)
        cnt[k] <= 32'h0000_0000;
    end
    else
    begin
      for (int k = 0; k < NUM_OL; k++)
      begin
        if (!(stage_on[k] && below[k]))
          cnt[k] <= 32'h0000_0000;
        else if (cnt[k] != 32'(FILTER_CYCLES))
          cnt[k] <= cnt[k] + 32'h0000_0001;
      end
    end
  end

  // Sticky flags; a new detection beats a clear in the same cycle, and a
  // load still missing after a clear is flagged again at once
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag <= '0;
    else
    begin
      for (int k = 0; k < NUM_OL; k++)
      begin
        if (stage_on[k] && below[k] && cnt[k] >= 32'(FILTER_CYCLES - 1))
          flag[k] <= 1'b1;
        else if (clear)
          flag[k] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  for (genvar k = 0; k < NUM_OL; k++)
  begin : g_chk
    ol_only_on_a: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(flag[k]) |-> $past(stage_on[k]))
      else $error("missing-load flag set on a stage that was off");
    ol_filter_a: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(flag[k]) |-> $past(cnt[k]) >= 32'(FILTER_CYCLES - 1))
      else $error("missing-load flag set before the filter time");
  end
endmodule
`default_nettype wire

// *** bench/dps_host.sv ***
// Host model: control writes, stage switching and fault clearing
`default_nettype none
module dps_host (
  input  wire logic                       clk,
  output logic                            ctrl_wr,
  output logic [15:0]                     ctrl_wdata,
  output logic                            oc_clear,
  output logic [dps_pkg::NUM_OUT-1:0]     out_on
);
  timeunit 1ns;
  timeprecision 1ps;
  import dps_pkg::*;
  // ==========================================================
  // Idle values
  initial
  begin
    ctrl_wr    = 1'b0;
    ctrl_wdata = 16'h0000;
    oc_clear   = 1'b0;
    out_on     = '0;
  end
  // ==========================================================
  // Host actions
  // Idle data shows the inverse word so a stale value never looks valid
  task automatic write_ctrl(input logic [15:0] w);
    @(negedge clk);
    ctrl_wr    = 1'b1;
    ctrl_wdata = w;
    @(negedge clk);
    ctrl_wr    = 1'b0;
    ctrl_wdata = ~w;
  endtask
  task automatic set_outputs(input logic [NUM_OUT-1:0] m);
    @(negedge clk);
    out_on = m;
  endtask
  // Short switch-on probes the loads without moving them
  task automatic pulse_outputs(input logic [NUM_OUT-1:0] m, input int n);
    set_outputs(m);
    repeat (n) @(negedge clk);
    out_on = '0;
  endtask
  task automatic clear_faults;
    @(negedge clk);
    oc_clear = 1'b1;
    @(negedge clk);
    oc_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/dps_top_tb.sv ***
// Self-checking bench for the protection status bits
`default_nettype none
module dps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dps_pkg::*;
  // ==========================================================
  // Signals; filter and start-up counts shrunk for a short run
  localparam int OLC = 20;
  localparam int SUC = 10;
  logic               clk, nrst, ctrl_wr, oc_clear, active_mode;
  logic               pwm_in, not_ready;
  logic [15:0]        ctrl_wdata, status_word;
  logic [NUM_OUT-1:0] out_on, oc_detect, below_thresh, drive_on, oc_flag;
  logic [31:0]        r;
  int                 num_errors, check_count, seed, n, m, lim, d;
  // ==========================================================
  // Design and host
  dps_top #(.OL_FILTER_CYCLES(OLC), .STARTUP_CYCLES(SUC)) u_dps_top (
    .clk(clk), .nrst(nrst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .oc_clear(oc_clear), .out_on(out_on), .oc_detect(oc_detect),
    .below_thresh(below_thresh), .active_mode(active_mode),
    .pwm_in(pwm_in), .drive_on(drive_on), .oc_flag(oc_flag),
    .not_ready(not_ready), .status_word(status_word)
  );
  dps_host u_dps_host (
    .clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .oc_clear(oc_clear), .out_on(out_on)
  );
  // ==========================================================
  // Helpers
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Gating masks only the two high-side switches
  function automatic logic [7:0] exp_drive(input logic [7:0] on,
    input logic [1:0] pe, input logic p);
    exp_drive = on & ~({pe, 6'h00} & {8{~p}});
  endfunction
  // Stage index 7..3 lands on status bits 8..4
  function automatic logic [15:0] exp_ol(input logic [7:0] f);
    exp_ol = {7'h00, f[7:3], 4'h0};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
    input string s);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog at about twice the expected run
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  // ==========================================================
  // Scenarios
  initial
  begin
    seed = 49;
    num_errors = 0;
    check_count = 0;
    nrst = 1'b0;
    active_mode = 1'b1;
    pwm_in = 1'b0;
    oc_detect = '0;
    below_thresh = '0;
    repeat (12) @(negedge clk);
    chk({drive_on, oc_flag}, 16'h0000, "reset");
    chk(status_word, STATUS_RESET, "reset status");
    // Start-up span: flag counted in cycles, stages held off
    u_dps_host.set_outputs(8'hC0);
    nrst = 1'b1;
    n = 0;
    m = 0;
    repeat (SUC + 6)
    begin
      @(negedge clk);
      n += int'(not_ready === 1'b1);
      m += int'(status_word[ST_NOT_READY] === 1'b1);
      if (not_ready === 1'b1)
        chk(16'(drive_on), 16'h0000, "startup drive");
    end
    chk(16'(n), 16'(SUC), "nr length");
    chk(16'(m), 16'(SUC), "nr status");
    chk(16'(drive_on), 16'h00C0, "after startup");
    active_mode = 1'b0;
    repeat (3) @(negedge clk);
    chk(16'(drive_on), 16'h0000, "standby");
    active_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(not_ready), 16'h0001, "restart");
    repeat (SUC + 2) @(negedge clk);
    chk(16'(drive_on), 16'h00C0, "resume");
    // Gating follows the PWM input, then random patterns
    u_dps_host.write_ctrl(16'h0030);
    @(negedge clk);
    chk(16'(drive_on), 16'h0000, "pwm low");
    pwm_in = 1'b1;
    @(negedge clk);
    chk(16'(drive_on), 16'h00C0, "pwm high");
    repeat (50)
    begin
      r = $random(seed);
      u_dps_host.write_ctrl({10'h000, r[9:8], 4'h0});
      u_dps_host.set_outputs(r[7:0]);
      pwm_in = r[10];
      @(negedge clk);
      chk(16'(drive_on), 16'(exp_drive(r[7:0], r[9:8], r[10])), "rnd");
    end
    // Trip without retry stays off until the host clears it
    u_dps_host.write_ctrl(16'h0000);
    u_dps_host.set_outputs(8'hC0);
    @(negedge clk);
    oc_detect = 8'h40;
    @(negedge clk);
    oc_detect = 8'h00;
    chk({drive_on, oc_flag}, 16'h8040, "trip");
    repeat (200) @(negedge clk);
    chk({drive_on, oc_flag}, 16'h8040, "held off");
    u_dps_host.clear_faults();
    repeat (2) @(negedge clk);
    chk({drive_on, oc_flag}, 16'hC000, "cleared");
    // Automatic retry, both duty settings
    for (d = 0; d < 2; d++)
    begin
      lim = d ? int'(RETRY_LONG_TICKS) : int'(RETRY_SHORT_TICKS);
      u_dps_host.write_ctrl({2'b00, d[0], 2'b00, 5'h10, 6'h00});
      @(negedge clk);
      oc_detect = 8'h80;
      @(negedge clk);
      oc_detect = 8'h00;
      chk({drive_on, oc_flag}, 16'h4080, "retry trip");
      n = 0;
      while (drive_on[7] !== 1'b1 && n < 12000)
      begin
        @(negedge clk);
        n++;
      end
      m = int'(n >= (lim - 1) * RETRY_DIV && n <= (lim + 1) * RETRY_DIV + 4);
      chk(16'(m), 16'h0001, "retry delay");
      u_dps_host.clear_faults();
    end
    // Missing load: idle stages ignored, gaps restart the filter
    u_dps_host.write_ctrl(16'h0000);
    u_dps_host.set_outputs(8'h00);
    repeat (OLC + 5)
    begin
      r = $random(seed);
      below_thresh = r[7:0];
      @(negedge clk);
    end
    chk(status_word, 16'h0000, "idle stages");
    below_thresh = 8'hFF;
    u_dps_host.pulse_outputs(8'hF8, OLC - 2);
    u_dps_host.pulse_outputs(8'hF8, OLC - 2);
    repeat (3) @(negedge clk);
    chk(status_word, 16'h0000, "short pulses");
    u_dps_host.pulse_outputs(8'hF8, OLC + 3);
    repeat (3) @(negedge clk);
    chk(status_word, exp_ol(8'hF8), "missing load");
    u_dps_host.clear_faults();
    @(negedge clk);
    chk(status_word, 16'h0000, "flags cleared");
    report_and_stop();
  end
endmodule
`default_nettype wire
